/* File: rtl/ssu_sync_serial.sv */
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Reception starts only when single or continuous receive enable is set.
// - Incoming data is sampled on the falling edge of the shift clock.
// - Single receive enable alone receives exactly one word in master mode, then stops; in slave mode it receives nothing.
// - Continuous receive enable receives words back to back until cleared.
// - With both enables set, continuous reception wins.
// - Each received word sets the receive flag; interrupt only if enabled.
// - Received ninth bit and overrun error bit appear in receive status control.
// - Lower eight received bits are readable in the receive buffer.
// - Clearing continuous receive enable clears pending receive errors.
// - Words are nine bits when nine-bit receive is set, else eight.
// - Clocked mode, port enable and clock source set give master operation.
// - Clocked mode and port enable with clock source clear give slave.
// - In slave mode the clock pin is not driven; the peer supplies it.
// - Slave transfers need no internal clock gating, so work in sleep.
// - Two buffered words: first shifts at once, second waits, flag clear.
// - After first word shifts out, second loads, then empty flag sets.
// - Buffer empty event requests a wake interrupt when enabled.
// - Polarity bits invert the clock line and the data line.
// - Master shift clock rate comes from the low divisor, or from the high and low divisors when sixteen-bit divisor select is set.
// - Empty flag sets on buffer to shifter move, clears on buffer write.
// - Half duplex: reception blocks transmitting, and a receive request aborts a transmission.
// - Clock polarity set gives a high idle clock, clear a low idle.
module ssu_sync_serial (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_clk_pin_i,
  output logic serial_clk_pin_o,
  output logic serial_clk_pin_oe,
  input wire logic data_line_pin_i,
  output logic data_line_pin_o,
  output logic data_line_pin_oe,
  output logic rx_irq_req,
  output logic tx_irq_req
);
  typedef enum logic [1:0] {SSU_IDLE, SSU_RX, SSU_TX} ssu_state_t;

  ssu_state_t state_q;
  logic serial_port_enable_q, rx9_q, single_receive_enable_q, continuous_receive_enable_q, oerr_q, rx9d_q;
  logic clock_source_select_q, tx9_q, transmit_enable_q, sync_q, transmit_ninth_bit_q;
  logic data_polarity_invert_q, clock_polarity_invert_q, sixteen_bit_divisor_select_q, receive_irq_enable_q, transmit_irq_enable_q;
  logic [7:0] divh_q, divl_q, txbuf_q, rcbuf_q;
  logic txbuf_full_q, transmit_buffer_empty_flag_q, receive_flag_q;
  logic [8:0] rsr_q, tsr_q;
  logic [3:0] bitcnt_q;
  logic [15:0] cnt_q;
  logic ck_int_q, ck_prev_q;
  logic [1:0] pin_sync;
  logic [7:0] rd_val;
  logic setup, acc, wr, rd, mapped;
  logic en, master, slave, rx_req, ck_lvl, din, fall_ev, tick;
  logic [15:0] limit;
  logic [3:0] rx_last, tx_last;
  logic rx_done, tx_end, load_tsr, wr_txbuf, rd_rcbuf, wr_rcs;

  ssu_sync2 #(.WIDTH(2)) u_pin_sync (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .d({serial_clk_pin_i, data_line_pin_i}),
    .q(pin_sync)
  );

  // APB slave, zero wait states
  assign setup = psel & ~penable;
  assign acc = psel & penable & pready;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;
  assign mapped = paddr <= ssu_pkg::ADDR_SERIAL_FLAGS && paddr[1:0] == 2'h0;
  assign wr_txbuf = wr && paddr == ssu_pkg::ADDR_TRANSMIT_BUFFER;
  assign rd_rcbuf = rd && paddr == ssu_pkg::ADDR_RECEIVE_BUFFER;
  assign wr_rcs = wr && paddr == ssu_pkg::ADDR_RCV_STATUS_CONTROL;

  always_comb
  begin
    rd_val = 8'h00;
    case (paddr)
      ssu_pkg::ADDR_RCV_STATUS_CONTROL: rd_val = {serial_port_enable_q, rx9_q, single_receive_enable_q, continuous_receive_enable_q, 2'h0, oerr_q, rx9d_q};
      ssu_pkg::ADDR_RECEIVE_BUFFER: rd_val = rcbuf_q;
      ssu_pkg::ADDR_XMT_STATUS_CONTROL: rd_val = {clock_source_select_q, tx9_q, transmit_enable_q, sync_q, 2'h0,
        state_q != SSU_TX, transmit_ninth_bit_q};
      ssu_pkg::ADDR_BAUD_POLARITY_CONTROL: rd_val = {2'h0, data_polarity_invert_q, clock_polarity_invert_q, sixteen_bit_divisor_select_q, 3'h0};
      ssu_pkg::ADDR_BAUD_DIVISOR_HIGH: rd_val = divh_q;
      ssu_pkg::ADDR_BAUD_DIVISOR_LOW: rd_val = divl_q;
      ssu_pkg::ADDR_TRANSMIT_BUFFER: rd_val = txbuf_q;
      ssu_pkg::ADDR_SERIAL_FLAGS: rd_val = {2'h0, receive_irq_enable_q, transmit_irq_enable_q, 2'h0, receive_flag_q, transmit_buffer_empty_flag_q};
      default: rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      if (setup)
        prdata <= {24'h0, rd_val};
    end
  end

  // Configuration registers
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      {serial_port_enable_q, rx9_q} <= ssu_pkg::RST_RCV_STATUS_CONTROL[7:6];
      {clock_source_select_q, tx9_q, transmit_enable_q, sync_q} <= ssu_pkg::RST_XMT_STATUS_CONTROL[7:4];
      transmit_ninth_bit_q <= ssu_pkg::RST_XMT_STATUS_CONTROL[0];
      {data_polarity_invert_q, clock_polarity_invert_q, sixteen_bit_divisor_select_q} <= ssu_pkg::RST_BAUD_POLARITY_CONTROL[5:3];
      divh_q <= ssu_pkg::RST_BAUD_DIVISOR;
      divl_q <= ssu_pkg::RST_BAUD_DIVISOR;
      {receive_irq_enable_q, transmit_irq_enable_q} <= ssu_pkg::RST_SERIAL_FLAGS[5:4];
    end
    else if (wr)
    begin
      case (paddr)
        ssu_pkg::ADDR_RCV_STATUS_CONTROL:
        begin
          serial_port_enable_q <= pwdata[ssu_pkg::RCS_SERIAL_PORT_ENABLE];
          rx9_q <= pwdata[ssu_pkg::RCS_NINE_BIT_RECEIVE];
        end
        ssu_pkg::ADDR_XMT_STATUS_CONTROL:
        begin
          clock_source_select_q <= pwdata[ssu_pkg::TXS_CLOCK_SOURCE_SELECT];
          tx9_q <= pwdata[ssu_pkg::TXS_NINE_BIT_TRANSMIT];
          transmit_enable_q <= pwdata[ssu_pkg::TXS_TRANSMIT_ENABLE];
          sync_q <= pwdata[ssu_pkg::TXS_CLOCKED_MODE_SELECT];
          transmit_ninth_bit_q <= pwdata[ssu_pkg::TXS_TRANSMIT_NINTH_BIT];
        end
        ssu_pkg::ADDR_BAUD_POLARITY_CONTROL:
        begin
          data_polarity_invert_q <= pwdata[ssu_pkg::BPC_DATA_POLARITY_INVERT];
          clock_polarity_invert_q <= pwdata[ssu_pkg::BPC_CLOCK_POLARITY_INVERT];
          sixteen_bit_divisor_select_q <= pwdata[ssu_pkg::BPC_SIXTEEN_BIT_DIVISOR];
        end
        ssu_pkg::ADDR_BAUD_DIVISOR_HIGH: divh_q <= pwdata[7:0];
        ssu_pkg::ADDR_BAUD_DIVISOR_LOW: divl_q <= pwdata[7:0];
        ssu_pkg::ADDR_SERIAL_FLAGS:
        begin
          receive_irq_enable_q <= pwdata[ssu_pkg::FLG_RECEIVE_IRQ_ENABLE];
          transmit_irq_enable_q <= pwdata[ssu_pkg::FLG_TRANSMIT_IRQ_ENABLE];
        end
        default: ;
      endcase
    end
  end

  // Mode decode
  assign en = serial_port_enable_q & sync_q;
  assign master = en & clock_source_select_q;
  assign slave = en & ~clock_source_select_q;
  assign rx_req = continuous_receive_enable_q | (single_receive_enable_q & master);
  assign ck_lvl = pin_sync[1] ^ clock_polarity_invert_q;
  assign din = pin_sync[0] ^ data_polarity_invert_q;
  assign limit = sixteen_bit_divisor_select_q ? {divh_q, divl_q} : {8'h00, divl_q};
  assign tick = master && state_q == SSU_RX && cnt_q == limit;
  assign fall_ev = master ? (tick & ck_int_q) : (slave & ck_prev_q & ~ck_lvl);
  assign rx_last = rx9_q ? ssu_pkg::WORD_LAST_NINE : ssu_pkg::WORD_LAST_EIGHT;
  assign tx_last = tx9_q ? ssu_pkg::WORD_LAST_NINE : ssu_pkg::WORD_LAST_EIGHT;
  assign rx_done = state_q == SSU_RX && rx_req && en && fall_ev && bitcnt_q == rx_last;
  assign tx_end = state_q == SSU_TX && fall_ev && bitcnt_q == tx_last;
  assign load_tsr = slave && transmit_enable_q && !rx_req && txbuf_full_q && !wr_txbuf
    && (state_q == SSU_IDLE || tx_end);

  // Master shift clock generator, idles low internally
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_q <= 16'h0000;
      ck_int_q <= 1'b0;
    end
    else if (master && state_q == SSU_RX)
    begin
      if (tick)
      begin
        cnt_q <= 16'h0000;
        ck_int_q <= ~ck_int_q;
      end
      else
        cnt_q <= cnt_q + 16'h0001;
    end
    else
    begin
      cnt_q <= 16'h0000;
      ck_int_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      ck_prev_q <= 1'b0;
    else
      ck_prev_q <= ck_lvl;
  end

  // Transfer sequencer, one direction at a time
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= SSU_IDLE;
      bitcnt_q <= 4'h0;
      rsr_q <= 9'h000;
      tsr_q <= 9'h000;
    end
    else
    begin
      case (state_q)
        SSU_IDLE:
        begin
          bitcnt_q <= 4'h0;
          if (en && rx_req)
            state_q <= SSU_RX;
          else if (load_tsr)
          begin
            tsr_q <= {transmit_ninth_bit_q, txbuf_q};
            state_q <= SSU_TX;
          end
        end
        SSU_RX:
        begin
          if (!en || !rx_req)
            state_q <= SSU_IDLE;
          else if (fall_ev)
          begin
            rsr_q[bitcnt_q] <= din;
            if (bitcnt_q == rx_last)
            begin
              bitcnt_q <= 4'h0;
              if (!continuous_receive_enable_q)
                state_q <= SSU_IDLE;
            end
            else
              bitcnt_q <= bitcnt_q + 4'h1;
          end
        end
        SSU_TX:
        begin
          if (!slave || !transmit_enable_q || rx_req)
            state_q <= SSU_IDLE;
          else if (fall_ev)
          begin
            if (bitcnt_q == tx_last)
            begin
              bitcnt_q <= 4'h0;
              if (load_tsr)
                tsr_q <= {transmit_ninth_bit_q, txbuf_q};
              else
                state_q <= SSU_IDLE;
            end
            else
              bitcnt_q <= bitcnt_q + 4'h1;
          end
        end
        default: state_q <= SSU_IDLE;
      endcase
    end
  end

  // Receive enables, result and flags
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      single_receive_enable_q <= ssu_pkg::RST_RCV_STATUS_CONTROL[5];
      continuous_receive_enable_q <= ssu_pkg::RST_RCV_STATUS_CONTROL[4];
      oerr_q <= ssu_pkg::RST_RCV_STATUS_CONTROL[1];
      rx9d_q <= ssu_pkg::RST_RCV_STATUS_CONTROL[0];
      rcbuf_q <= ssu_pkg::RST_BUFFER;
      receive_flag_q <= ssu_pkg::RST_SERIAL_FLAGS[1];
    end
    else
    begin
      if (wr_rcs)
      begin
        single_receive_enable_q <= pwdata[ssu_pkg::RCS_SINGLE_RECEIVE_ENABLE];
        continuous_receive_enable_q <= pwdata[ssu_pkg::RCS_CONTINUOUS_RECEIVE_ENABLE];
      end
      else if (rx_done && !continuous_receive_enable_q)
        single_receive_enable_q <= 1'b0;
      if (rx_done && receive_flag_q)
        oerr_q <= 1'b1;
      else if (!continuous_receive_enable_q)
        oerr_q <= 1'b0;
      if (rx_done && !receive_flag_q)
        rx9d_q <= rx9_q ? din : 1'b0;
      if (rx_done && !receive_flag_q && !rx9_q)
        rcbuf_q <= {din, rsr_q[6:0]};
      else if (rx_done && !receive_flag_q)
        rcbuf_q <= rsr_q[7:0];
      if (rx_done)
        receive_flag_q <= 1'b1;
      else if (rd_rcbuf)
        receive_flag_q <= 1'b0;
    end
  end

  // Transmit buffer and its empty flag
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      txbuf_q <= ssu_pkg::RST_BUFFER;
      txbuf_full_q <= 1'b0;
      transmit_buffer_empty_flag_q <= ssu_pkg::RST_SERIAL_FLAGS[0];
    end
    else if (wr_txbuf)
    begin
      txbuf_q <= pwdata[7:0];
      txbuf_full_q <= 1'b1;
      transmit_buffer_empty_flag_q <= 1'b0;
    end
    else if (load_tsr)
    begin
      txbuf_full_q <= 1'b0;
      transmit_buffer_empty_flag_q <= 1'b1;
    end
  end

  // Registered pins and requests
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      serial_clk_pin_o <= 1'b0;
      serial_clk_pin_oe <= 1'b0;
      data_line_pin_o <= 1'b0;
      data_line_pin_oe <= 1'b0;
      rx_irq_req <= 1'b0;
      tx_irq_req <= 1'b0;
    end
    else
    begin
      serial_clk_pin_o <= ck_int_q ^ clock_polarity_invert_q;
      serial_clk_pin_oe <= master;
      data_line_pin_o <= (state_q == SSU_TX ? tsr_q[bitcnt_q] : 1'b0) ^ data_polarity_invert_q;
      data_line_pin_oe <= state_q == SSU_TX;
      rx_irq_req <= receive_flag_q & receive_irq_enable_q;
      tx_irq_req <= transmit_buffer_empty_flag_q & transmit_irq_enable_q;
    end
  end

  sequence s_word_in;
    rx_done ##1 receive_flag_q;
  endsequence

  sequence s_single_stop;
    !single_receive_enable_q && state_q == SSU_IDLE;
  endsequence

  property p_rx_flag;
    @(posedge clk_sys) disable iff (!rstn) rx_done |-> s_word_in;
  endproperty
  a_rx_flag: assert property (p_rx_flag) else $error("receive flag not set");

  property p_single;
    @(posedge clk_sys) disable iff (!rstn) rx_done && !continuous_receive_enable_q && !wr_rcs |=> s_single_stop;
  endproperty
  a_single: assert property (p_single) else $error("single word did not stop");

  property p_cont;
    @(posedge clk_sys) disable iff (!rstn) rx_done && continuous_receive_enable_q && !wr_rcs |=> state_q == SSU_RX;
  endproperty
  a_cont: assert property (p_cont) else $error("continuous reception stopped");

  property p_overrun;
    @(posedge clk_sys) disable iff (!rstn) rx_done && receive_flag_q |=> oerr_q;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun missed");

  property p_err_clear;
    @(posedge clk_sys) disable iff (!rstn) !continuous_receive_enable_q && !rx_done |=> !oerr_q;
  endproperty
  a_err_clear: assert property (p_err_clear) else $error("error not cleared");

  property p_load;
    @(posedge clk_sys) disable iff (!rstn) load_tsr |=> transmit_buffer_empty_flag_q && !txbuf_full_q ##1 state_q == SSU_TX;
  endproperty
  a_load: assert property (p_load) else $error("shifter load wrong");

  property p_duplex;
    @(posedge clk_sys) disable iff (!rstn) data_line_pin_oe |-> $past(state_q) == SSU_TX && !$past(rx_req);
  endproperty
  a_duplex: assert property (p_duplex) else $error("data driven off transmit");

  property p_slave_clk;
    @(posedge clk_sys) disable iff (!rstn) slave |=> !serial_clk_pin_oe;
  endproperty
  a_slave_clk: assert property (p_slave_clk) else $error("slave drove clock");

  property p_rate;
    @(posedge clk_sys) disable iff (!rstn) $changed(ck_int_q) && $past(master && state_q == SSU_RX)
      |-> $past(cnt_q) == $past(limit);
  endproperty
  a_rate: assert property (p_rate) else $error("clock edge off divisor");

  property p_idle_level;
    @(posedge clk_sys) disable iff (!rstn) state_q == SSU_IDLE ##2 state_q == SSU_IDLE
      |-> serial_clk_pin_o == clock_polarity_invert_q || $changed(clock_polarity_invert_q);
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("clock idle level wrong");
endmodule // ssu_sync_serial
`default_nettype wire

/* File: rtl/ssu_pkg.sv */
package ssu_pkg;
  // Register byte addresses on the APB bus
  localparam logic [7:0] ADDR_RCV_STATUS_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_RECEIVE_BUFFER = 8'h04;
  localparam logic [7:0] ADDR_XMT_STATUS_CONTROL = 8'h08;
  localparam logic [7:0] ADDR_BAUD_POLARITY_CONTROL = 8'h0C;
  localparam logic [7:0] ADDR_BAUD_DIVISOR_HIGH = 8'h10;
  localparam logic [7:0] ADDR_BAUD_DIVISOR_LOW = 8'h14;
  localparam logic [7:0] ADDR_TRANSMIT_BUFFER = 8'h18;
  localparam logic [7:0] ADDR_SERIAL_FLAGS = 8'h1C;
  // receive_status_control fields
  localparam int unsigned RCS_SERIAL_PORT_ENABLE = 7;
  localparam int unsigned RCS_NINE_BIT_RECEIVE = 6;
  localparam int unsigned RCS_SINGLE_RECEIVE_ENABLE = 5;
  localparam int unsigned RCS_CONTINUOUS_RECEIVE_ENABLE = 4;
  localparam int unsigned RCS_FRAMING_ERROR = 2;
  localparam int unsigned RCS_OVERRUN_ERROR = 1;
  localparam int unsigned RCS_RECEIVED_NINTH_BIT = 0;
  // transmit_status_control fields
  localparam int unsigned TXS_CLOCK_SOURCE_SELECT = 7;
  localparam int unsigned TXS_NINE_BIT_TRANSMIT = 6;
  localparam int unsigned TXS_TRANSMIT_ENABLE = 5;
  localparam int unsigned TXS_CLOCKED_MODE_SELECT = 4;
  localparam int unsigned TXS_SHIFT_EMPTY_FLAG = 1;
  localparam int unsigned TXS_TRANSMIT_NINTH_BIT = 0;
  // baud_polarity_control fields
  localparam int unsigned BPC_DATA_POLARITY_INVERT = 5;
  localparam int unsigned BPC_CLOCK_POLARITY_INVERT = 4;
  localparam int unsigned BPC_SIXTEEN_BIT_DIVISOR = 3;
  // serial_flags fields
  localparam int unsigned FLG_RECEIVE_IRQ_ENABLE = 5;
  localparam int unsigned FLG_TRANSMIT_IRQ_ENABLE = 4;
  localparam int unsigned FLG_RECEIVE_FLAG = 1;
  localparam int unsigned FLG_TRANSMIT_BUFFER_EMPTY = 0;
  // Reset values
  localparam logic [7:0] RST_RCV_STATUS_CONTROL = 8'h00;
  localparam logic [7:0] RST_XMT_STATUS_CONTROL = 8'h02;
  localparam logic [7:0] RST_BAUD_POLARITY_CONTROL = 8'h00;
  localparam logic [7:0] RST_BAUD_DIVISOR = 8'h00;
  localparam logic [7:0] RST_BUFFER = 8'h00;
  localparam logic [7:0] RST_SERIAL_FLAGS = 8'h01;
  // Index of the last bit of a word
  localparam logic [3:0] WORD_LAST_EIGHT = 4'h7;
  localparam logic [3:0] WORD_LAST_NINE = 4'h8;
endpackage

/* File: rtl/ssu_sync2.sv */
`timescale 1ns/10ps
`default_nettype none
module ssu_sync2 #(
  parameter int unsigned WIDTH = 2
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_q;

  // Two flops per bit; the first stage is read only by the second
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      meta_q <= '0;
      q <= '0;
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule // ssu_sync2
`default_nettype wire

/* File: dv/ssu_peer.sv */
`timescale 1ns/10ps
`default_nettype none
module ssu_peer (
  input wire logic ck_line,
  input wire logic dt_line,
  input wire logic cpol,
  input wire logic talk,
  input wire logic [8:0] word,
  input wire logic [3:0] nbits,
  output logic ck_drv,
  output logic dt_drv,
  output logic [8:0] got
);
  wire logic ck_int = ck_line ^ cpol;
  int idx;
  int gidx;
  initial
  begin
    ck_drv = 1'b0;
    dt_drv = 1'b0;
    got = '0;
    idx = 0;
    gidx = 0;
  end
  // Park the clock first; an edge it makes must not shift the counters
  task automatic restart();
    ck_drv = cpol;
    #1;
    idx = 0;
    gidx = 0;
    got = '0;
  endtask
  // Slave shift clock, still between frames
  task automatic clocks(input int n);
    repeat (n)
    begin
      #100 ck_drv = ~cpol;
      #100 ck_drv = cpol;
    end
  endtask
  // New bit after the rise so it is stable at the sampling fall; idle line keeps changing
  always @(posedge ck_int)
  begin
    if (talk)
    begin
      dt_drv <= word[idx];
      idx <= (idx + 1 == nbits) ? 0 : idx + 1;
    end
    else
      dt_drv <= ~dt_drv;
  end
  always @(negedge ck_int)
  begin
    got[gidx] <= dt_line;
    gidx <= (gidx + 1 == nbits) ? 0 : gidx + 1;
  end
endmodule // ssu_peer
`default_nettype wire

/* File: dv/ssu_sync_serial_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module ssu_sync_serial_tb_top;
  logic clk_sys;
  logic rstn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic ck_o;
  logic ck_oe;
  logic dt_o;
  logic dt_oe;
  logic rx_irq_req;
  logic tx_irq_req;
  logic pk_drv;
  logic pd_drv;
  logic cpol;
  logic talk;
  logic [8:0] word;
  logic [3:0] nbits;
  logic [8:0] got;
  logic [31:0] rd;
  logic rerr;
  int err_count;
  int samples_checked;
  wire logic ck_line = ck_oe ? ck_o : pk_drv;
  wire logic dt_line = dt_oe ? dt_o : pd_drv;
  ssu_sync_serial dut (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_clk_pin_i(ck_line), .serial_clk_pin_o(ck_o), .serial_clk_pin_oe(ck_oe),
    .data_line_pin_i(dt_line), .data_line_pin_o(dt_o), .data_line_pin_oe(dt_oe),
    .rx_irq_req(rx_irq_req), .tx_irq_req(tx_irq_req));
  ssu_peer peer (.ck_line(ck_line), .dt_line(dt_line), .cpol(cpol), .talk(talk), .word(word),
    .nbits(nbits), .ck_drv(pk_drv), .dt_drv(pd_drv), .got(got));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      err_count++;
      $display("unexpected %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 20);
    chk("pready", 1, pready);
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(nm, {24'h0, e}, rd & {24'h0, m});
  endtask
  task automatic wait_rx();
    int k;
    k = 0;
    do
    begin
      apb(1'b0, 8'h1C, 8'h00);
      k++;
    end while (rd[1] !== 1'b1 && k < 2000);
    chk("receive flag", 1, rd[1]);
  endtask
  task automatic hi_len(input int e);
    int n;
    int k;
    n = 0;
    k = 0;
    while ((ck_o ^ cpol) !== 1'b1 && k < 500)
    begin
      @(posedge clk_sys);
      k++;
    end
    while ((ck_o ^ cpol) === 1'b1 && n < 500)
    begin
      @(posedge clk_sys);
      n++;
    end
    chk("clock half period", e, n);
  endtask
  task automatic t_regs();
    rdc("rcs reset", 8'h00, 8'hFF, 8'h00);
    rdc("rbuf reset", 8'h04, 8'hFF, 8'h00);
    rdc("txs reset", 8'h08, 8'hFF, 8'h02);
    rdc("bpc reset", 8'h0C, 8'hFF, 8'h00);
    rdc("div hi reset", 8'h10, 8'hFF, 8'h00);
    rdc("div lo reset", 8'h14, 8'hFF, 8'h00);
    rdc("flags reset", 8'h1C, 8'hFF, 8'h01);
    apb(1'b1, 8'h1C, 8'hFF);
    rdc("flags ro", 8'h1C, 8'hFF, 8'h31);
    apb(1'b1, 8'h1C, 8'h00);
    apb(1'b0, 8'h20, 8'h00);
    chk("unmapped err", 1, rerr);
    $display("test regs done");
  endtask
  task automatic t_single();
    word = 9'h0A5;
    nbits = 4'h8;
    talk = 1'b1;
    apb(1'b1, 8'h10, 8'h01);
    apb(1'b1, 8'h14, 8'h03);
    apb(1'b1, 8'h08, 8'h90);
    apb(1'b1, 8'h1C, 8'h20);
    apb(1'b1, 8'h00, 8'h80);
    repeat (20) @(posedge clk_sys);
    chk("clock idle", 0, ck_o);
    chk("clock drive", 1, ck_oe);
    peer.restart();
    apb(1'b1, 8'h00, 8'hA0);
    hi_len(4);
    wait_rx();
    chk("rx irq", 1, rx_irq_req);
    rdc("rcs single", 8'h00, 8'hFF, 8'h80);
    rdc("rbuf", 8'h04, 8'hFF, 8'hA5);
    repeat (60) @(posedge clk_sys);
    rdc("flags single", 8'h1C, 8'hFF, 8'h21);
    chk("rx irq clear", 0, rx_irq_req);
    $display("test single done");
  endtask
  task automatic t_cont();
    word = 9'h15A;
    nbits = 4'h9;
    apb(1'b1, 8'h0C, 8'h08);
    apb(1'b1, 8'h10, 8'h01);
    apb(1'b1, 8'h14, 8'h04);
    peer.restart();
    apb(1'b1, 8'h00, 8'hF0);
    hi_len(261);
    wait_rx();
    rdc("rcs ninth", 8'h00, 8'hDF, 8'hD1);
    rdc("rbuf nine", 8'h04, 8'hFF, 8'h5A);
    wait_rx();
    repeat (5000) @(posedge clk_sys);
    rdc("overrun", 8'h00, 8'h02, 8'h02);
    apb(1'b1, 8'h00, 8'hC0);
    rdc("overrun clear", 8'h00, 8'h02, 8'h00);
    apb(1'b0, 8'h04, 8'h00);
    $display("test continuous done");
  endtask
  task automatic t_pol();
    word = 9'h0F0;
    nbits = 4'h8;
    cpol = 1'b1;
    apb(1'b1, 8'h0C, 8'h30);
    repeat (10) @(posedge clk_sys);
    chk("clock idle high", 1, ck_o);
    peer.restart();
    apb(1'b1, 8'h00, 8'hA0);
    hi_len(5);
    wait_rx();
    rdc("rbuf inverted", 8'h04, 8'hFF, 8'h0F);
    chk("clock idle after", 1, ck_o);
    $display("test polarity done");
  endtask
  task automatic t_slave();
    cpol = 1'b0;
    talk = 1'b0;
    nbits = 4'h8;
    apb(1'b1, 8'h00, 8'h80);
    apb(1'b1, 8'h0C, 8'h00);
    apb(1'b1, 8'h08, 8'h30);
    apb(1'b1, 8'h1C, 8'h10);
    peer.restart();
    repeat (10) @(posedge clk_sys);
    chk("slave clock released", 0, ck_oe);
    apb(1'b1, 8'h18, 8'h3C);
    apb(1'b1, 8'h18, 8'hC3);
    rdc("tbe after two", 8'h1C, 8'h01, 8'h00);
    chk("tx irq low", 0, tx_irq_req);
    chk("data drive", 1, dt_oe);
    peer.clocks(8);
    repeat (8) @(posedge clk_sys);
    chk("first word", 9'h03C, {1'b0, got[7:0]});
    rdc("tbe set", 8'h1C, 8'hFF, 8'h11);
    chk("tx irq", 1, tx_irq_req);
    peer.restart();
    peer.clocks(8);
    repeat (8) @(posedge clk_sys);
    chk("second word", 9'h0C3, {1'b0, got[7:0]});
    rdc("shift empty", 8'h08, 8'hFF, 8'h32);
    $display("test slave done");
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  initial
  begin
    repeat (40000) @(posedge clk_sys);
    err_count++;
    finish_test();
  end
  initial
  begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cpol = 1'b0;
    talk = 1'b0;
    word = 9'h000;
    nbits = 4'h8;
    err_count = 0;
    samples_checked = 0;
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    t_regs();
    t_single();
    t_cont();
    t_pol();
    t_slave();
    finish_test();
  end
endmodule // ssu_sync_serial_tb_top
`default_nettype wire
